// >>> logic/tor_axis_if.sv
// carrier between the bank and its per-axis angle rescaler
`timescale 1ns/1ps
interface tor_axis_if;
  logic signed [15:0] base;
  logic [1:0]         dec;
  logic signed [15:0] offset;
  logic signed [15:0] result;

  modport bank (output base, output dec, output offset, input result);
  modport calc (input base, input dec, input offset, output result);
endinterface : tor_axis_if

// >>> logic/tor_pkg.sv
// constants and state type of the inclinometer offset, rate and id bank
package tor_pkg;

  // register addresses
  localparam logic [15:0] ADDR_ANG_OFF_X  = 16'h0036;
  localparam logic [15:0] ADDR_ANG_OFF_Y  = 16'h0037;
  localparam logic [15:0] ADDR_ACC_OFF_X  = 16'h0038;
  localparam logic [15:0] ADDR_ACC_OFF_Y  = 16'h0039;
  localparam logic [15:0] ADDR_RATE_SEL   = 16'h003F;
  localparam logic [15:0] ADDR_CAL_FIRST  = 16'h0040;
  localparam logic [15:0] ADDR_CAL_LAST   = 16'h0047;
  localparam logic [15:0] ADDR_SERIAL_HI  = 16'hFFF0;
  localparam logic [15:0] ADDR_SERIAL_LO  = 16'hFFF1;
  localparam logic [15:0] ADDR_DEV_ID     = 16'hFFF2;
  localparam logic [15:0] ADDR_FW_VER     = 16'hFFF3;
  localparam logic [15:0] ADDR_BUILD_VER  = 16'hFFF4;

  // reset values and calibration read value
  localparam logic [15:0] RST_ANG_OFF     = 16'h0000;
  localparam logic [15:0] RST_ACC_OFF     = 16'h0000;
  localparam logic [1:0]  RST_RATE_SEL    = 2'h0;
  localparam logic [15:0] CAL_READ_VALUE  = 16'h0000;

  // accepted spans
  localparam logic signed [15:0] ANG_OFF_MIN = 16'shFC18;
  localparam logic signed [15:0] ANG_OFF_MAX = 16'sh03E8;
  localparam logic signed [15:0] ACC_OFF_MIN = 16'shFF9C;
  localparam logic signed [15:0] ACC_OFF_MAX = 16'sh0064;
  localparam logic [15:0]        RATE_MAX    = 16'h0002;

  // decimal position factors
  localparam logic signed [31:0] DEC_F0 = 32'sh0000_0001;
  localparam logic signed [31:0] DEC_F1 = 32'sh0000_000A;
  localparam logic signed [31:0] DEC_F2 = 32'sh0000_0064;
  localparam logic signed [31:0] DEC_F3 = 32'sh0000_03E8;

  // modbus exception codes
  localparam logic [7:0] EXC_NONE          = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

  // sample rates and derived divider periods
  localparam int unsigned CLK_HZ    = 20000000;
  localparam int unsigned RATE0_HZ  = 4;
  localparam int unsigned RATE1_HZ  = 7;
  localparam int unsigned RATE2_HZ  = 15;
  localparam int unsigned RATE0_CYC = CLK_HZ / RATE0_HZ;
  localparam int unsigned RATE1_CYC = CLK_HZ / RATE1_HZ;
  localparam int unsigned RATE2_CYC = CLK_HZ / RATE2_HZ;
  localparam int unsigned DIV_W     = 23;

  typedef struct packed {
    logic [1:0][15:0]  ang_off;
    logic [1:0][15:0]  acc_off;
    logic [1:0]        rate_sel;
    logic              rsp_valid;
    logic [7:0]        rsp_code;
    logic [15:0]       rsp_data;
    logic [1:0][15:0]  ang_res;
    logic [1:0][15:0]  acc_res;
    logic [DIV_W-1:0]  div_cnt;
    logic              tick;
  } tor_state_t;

endpackage : tor_pkg

// >>> logic/tor_regs.sv
// offset, rate and identity register bank of the inclinometer
`timescale 1ns/1ps
module tor_regs #(
  parameter int unsigned RATE0_CYC = tor_pkg::RATE0_CYC,
  parameter int unsigned RATE1_CYC = tor_pkg::RATE1_CYC,
  parameter int unsigned RATE2_CYC = tor_pkg::RATE2_CYC,
  // identity words: values arbitrary
  parameter logic [15:0] SERIAL_HI = 16'h0000,
  parameter logic [15:0] SERIAL_LO = 16'h0001,
  parameter logic [15:0] DEV_ID    = 16'hA5C3,
  parameter logic [15:0] FW_VER    = 16'h0100,
  parameter logic [15:0] BUILD_VER = 16'h0001
) (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 reset_i,
  // single-register request from the protocol engine
  input  wire logic                 req_valid_i,
  input  wire logic                 req_write_i,
  input  wire logic [15:0]          req_addr_i,
  input  wire logic [15:0]          req_wdata_i,
  input  wire logic                 write_allow_i,
  // answer to the protocol engine
  output logic                      rsp_valid_o,
  output logic                      rsp_exc_o,
  output logic [7:0]                rsp_code_o,
  output logic [15:0]               rsp_data_o,
  // measurement path
  input  wire logic signed [15:0]   angle_x_i,
  input  wire logic signed [15:0]   angle_y_i,
  input  wire logic [1:0]           decimal_x_i,
  input  wire logic [1:0]           decimal_y_i,
  input  wire logic signed [15:0]   accel_x_i,
  input  wire logic signed [15:0]   accel_y_i,
  output logic [15:0]               angle_result_x_o,
  output logic [15:0]               angle_result_y_o,
  output logic [15:0]               accel_result_x_o,
  output logic [15:0]               accel_result_y_o,
  // sampling
  output logic [1:0]                sample_rate_o,
  output logic                      sample_tick_o
);
  tor_pkg::tor_state_t state;
  tor_pkg::tor_state_t next_state;

  tor_axis_if axis [2] ();

  logic signed [15:0] ang_in [2];
  logic [1:0]         dec_in [2];
  logic signed [15:0] acc_in [2];
  logic [15:0]        ang_calc [2];

  assign ang_in[0] = angle_x_i;
  assign ang_in[1] = angle_y_i;
  assign dec_in[0] = decimal_x_i;
  assign dec_in[1] = decimal_y_i;
  assign acc_in[0] = accel_x_i;
  assign acc_in[1] = accel_y_i;

  // one rescaler per axis
  for (genvar g = 0; g < 2; g++)
  begin : g_axis
    assign axis[g].base   = ang_in[g];
    assign axis[g].dec    = dec_in[g];
    // offset passed as stored, never rescaled here
    assign axis[g].offset = state.ang_off[g];
    assign ang_calc[g]    = axis[g].result;
    tor_scale u_scale (
      .ax (axis[g])
    );
  end

  logic [tor_pkg::DIV_W-1:0] period_m1;
  logic                      is_cal;
  logic                      is_ro;
  logic                      is_rw;
  logic                      in_range;
  logic [15:0]               rd_data;
  logic signed [15:0]        wval;

  assign wval   = signed'(req_wdata_i);
  assign is_cal = (req_addr_i >= tor_pkg::ADDR_CAL_FIRST) &&
                  (req_addr_i <= tor_pkg::ADDR_CAL_LAST);

  always_comb
  begin
    case (state.rate_sel)
      2'h0:    period_m1 = tor_pkg::DIV_W'(RATE0_CYC - 1);
      2'h1:    period_m1 = tor_pkg::DIV_W'(RATE1_CYC - 1);
      default: period_m1 = tor_pkg::DIV_W'(RATE2_CYC - 1);
    endcase
  end

  // address decode, read mux and span checks
  always_comb
  begin
    is_ro    = 1'b0;
    is_rw    = 1'b0;
    in_range = 1'b0;
    rd_data  = 16'h0000;
    case (req_addr_i)
      tor_pkg::ADDR_ANG_OFF_X,
      tor_pkg::ADDR_ANG_OFF_Y:
      begin
        is_rw    = 1'b1;
        rd_data  = state.ang_off[req_addr_i[0]];
        in_range = (wval >= tor_pkg::ANG_OFF_MIN) &&
                   (wval <= tor_pkg::ANG_OFF_MAX);
      end
      tor_pkg::ADDR_ACC_OFF_X,
      tor_pkg::ADDR_ACC_OFF_Y:
      begin
        is_rw    = 1'b1;
        rd_data  = state.acc_off[req_addr_i[0]];
        in_range = (wval >= tor_pkg::ACC_OFF_MIN) &&
                   (wval <= tor_pkg::ACC_OFF_MAX);
      end
      tor_pkg::ADDR_RATE_SEL:
      begin
        is_rw    = 1'b1;
        rd_data  = {14'h0000, state.rate_sel};
        in_range = (req_wdata_i <= tor_pkg::RATE_MAX);
      end
      tor_pkg::ADDR_SERIAL_HI:
      begin
        is_ro   = 1'b1;
        rd_data = SERIAL_HI;
      end
      tor_pkg::ADDR_SERIAL_LO:
      begin
        is_ro   = 1'b1;
        rd_data = SERIAL_LO;
      end
      tor_pkg::ADDR_DEV_ID:
      begin
        is_ro   = 1'b1;
        rd_data = DEV_ID;
      end
      tor_pkg::ADDR_FW_VER:
      begin
        is_ro   = 1'b1;
        rd_data = FW_VER;
      end
      tor_pkg::ADDR_BUILD_VER:
      begin
        is_ro   = 1'b1;
        rd_data = BUILD_VER;
      end
      default:
      begin
        // calibration words readable but treated as read-only
        if (is_cal)
        begin
          is_ro   = 1'b1;
          rd_data = tor_pkg::CAL_READ_VALUE;
        end
      end
    endcase
  end

  always_comb
  begin
    next_state           = state;
    next_state.rsp_valid = 1'b0;
    next_state.tick      = 1'b0;

    // sample divider; >= compare survives a rate change mid-count
    if (state.div_cnt >= period_m1)
    begin
      next_state.div_cnt = '0;
      next_state.tick    = 1'b1;
    end
    else
    begin
      next_state.div_cnt = state.div_cnt + 1'b1;
    end

    // results refresh once per sample period
    if (state.tick)
    begin
      for (int i = 0; i < 2; i++)
      begin
        next_state.ang_res[i] = ang_calc[i];
        next_state.acc_res[i] = 16'(acc_in[i] - signed'(state.acc_off[i]));
      end
    end

    if (req_valid_i)
    begin
      next_state.rsp_valid = 1'b1;
      next_state.rsp_code  = tor_pkg::EXC_NONE;
      next_state.rsp_data  = rd_data;
      // exception answers, checked in priority order
      if (!is_ro && !is_rw)
        next_state.rsp_code = tor_pkg::EXC_ILLEGAL_ADDR;
      else if (req_write_i)
      begin
        next_state.rsp_data = req_wdata_i;
        if (is_ro)
          next_state.rsp_code = tor_pkg::EXC_ILLEGAL_FUNC;
        else if (!write_allow_i)
          next_state.rsp_code = tor_pkg::EXC_ILLEGAL_FUNC;
        else if (!in_range)
          next_state.rsp_code = tor_pkg::EXC_ILLEGAL_VALUE;
        else
        begin
          case (req_addr_i)
            // both angle offsets share the write path
            tor_pkg::ADDR_ANG_OFF_X,
            tor_pkg::ADDR_ANG_OFF_Y:
              next_state.ang_off[req_addr_i[0]] = req_wdata_i;
            // both acceleration offsets share the write path
            tor_pkg::ADDR_ACC_OFF_X,
            tor_pkg::ADDR_ACC_OFF_Y:
              next_state.acc_off[req_addr_i[0]] = req_wdata_i;
            tor_pkg::ADDR_RATE_SEL:
              next_state.rate_sel = req_wdata_i[1:0];
            default:
              next_state.rate_sel = state.rate_sel;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state          <= '0;
      state.ang_off  <= {2{tor_pkg::RST_ANG_OFF}};
      state.acc_off  <= {2{tor_pkg::RST_ACC_OFF}};
      state.rate_sel <= tor_pkg::RST_RATE_SEL;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rsp_valid_o      = state.rsp_valid;
  assign rsp_exc_o        = state.rsp_valid &&
                            (state.rsp_code != tor_pkg::EXC_NONE);
  assign rsp_code_o       = state.rsp_code;
  assign rsp_data_o       = state.rsp_data;
  assign angle_result_x_o = state.ang_res[0];
  assign angle_result_y_o = state.ang_res[1];
  assign accel_result_x_o = state.acc_res[0];
  assign accel_result_y_o = state.acc_res[1];
  assign sample_rate_o    = state.rate_sel;
  assign sample_tick_o    = state.tick;
endmodule : tor_regs

// >>> logic/tor_scale.sv
// angle rescaler: decimal factor applied, then offset removed
`timescale 1ns/1ps
module tor_scale (
  tor_axis_if.calc ax
);
  logic signed [31:0] factor;
  logic signed [31:0] product;
  logic signed [31:0] diff;

  always_comb
  begin
    case (ax.dec)
      2'h0:    factor = tor_pkg::DEC_F0;
      2'h1:    factor = tor_pkg::DEC_F1;
      2'h2:    factor = tor_pkg::DEC_F2;
      default: factor = tor_pkg::DEC_F3;
    endcase
  end

  // offset subtracted after rescale; top bits dropped, range is user's
  assign product   = 32'(signed'(ax.base)) * factor;
  assign diff      = product - 32'(signed'(ax.offset));
  assign ax.result = diff[15:0];
endmodule : tor_scale

// >>> tb/tor_master_model.sv
// bus master stand-in issuing single-register requests
`timescale 1ns/1ps
module tor_master_model (
  // clock
  input  wire logic        sys_clk_i,
  // request
  output logic             req_valid_o = 1'b0,
  output logic             req_write_o = 1'b0,
  output logic [15:0]      req_addr_o = 16'h0000,
  output logic [15:0]      req_wdata_o = 16'h0000,
  // answer
  input  wire logic        rsp_valid_i,
  input  wire logic [7:0]  rsp_code_i,
  input  wire logic [15:0] rsp_data_i
);
  task automatic xfer(input logic w, input logic [15:0] a, d,
                      output logic [7:0] c, output logic [15:0] q);
    if (w && a inside {[16'h0040:16'h0047]})
      w = 1'b0;
    @(posedge sys_clk_i);
    #2;
    req_valid_o = 1'b1;
    req_write_o = w;
    req_addr_o  = a;
    req_wdata_o = d;
    @(posedge sys_clk_i);
    #2;
    // released address and data lines flip so stale values cannot pass
    req_valid_o = 1'b0;
    req_addr_o  = ~a;
    req_wdata_o = ~d;
    c = rsp_valid_i ? rsp_code_i : 8'hEE;
    q = rsp_data_i;
  endtask : xfer
endmodule : tor_master_model

// >>> tb/tor_regs_sva.sv
// assertions on the register bank ports
`timescale 1ns/1ps
module tor_regs_sva (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  // request
  input wire logic        req_valid_i,
  input wire logic        req_write_i,
  input wire logic [15:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic        write_allow_i,
  // answer and rate
  input wire logic        rsp_valid_o,
  input wire logic        rsp_exc_o,
  input wire logic [7:0]  rsp_code_o,
  input wire logic [1:0]  sample_rate_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic               wr;
  logic               ro;
  logic               ang;
  logic               acl;
  logic               rsel;
  logic signed [15:0] v;
  // refused writes must not reach the span checks, hence the allow term
  assign v    = req_wdata_i;
  assign wr   = req_valid_i && req_write_i;
  assign ro   = req_addr_i inside {[16'h0040:16'h0047], [16'hFFF0:16'hFFF4]};
  assign ang  = req_addr_i inside {16'h0036, 16'h0037};
  assign acl  = req_addr_i inside {16'h0038, 16'h0039};
  assign rsel = req_addr_i == 16'h003F;

  answer_next_cycle_a: assert property (
    req_valid_i |=> rsp_valid_o ##1 (!rsp_valid_o || $past(req_valid_i)))
    else $error("answer not one cycle after request");
  unmapped_exception_a: assert property (
    req_valid_i && !(ro || ang || acl || rsel)
      |=> rsp_exc_o && rsp_code_o == 8'h02)
    else $error("unmapped access not refused");
  readonly_write_a: assert property (
    wr && ro |=> rsp_exc_o && rsp_code_o == 8'h01)
    else $error("read-only write not refused");
  write_denied_a: assert property (
    wr && (ang || acl || rsel) && !write_allow_i
      |=> rsp_code_o == 8'h01 && $stable(sample_rate_o))
    else $error("write without permission not refused");
  angle_span_a: assert property (
    wr && ang && write_allow_i && (v < -1000 || v > 1000)
      |=> rsp_exc_o && rsp_code_o == 8'h03)
    else $error("angle offset span not enforced");
  accel_span_a: assert property (
    wr && acl && write_allow_i && (v < -100 || v > 100)
      |=> rsp_exc_o && rsp_code_o == 8'h03)
    else $error("accel offset span not enforced");
  rate_span_a: assert property (
    wr && rsel && write_allow_i && req_wdata_i > 16'h0002
      |=> rsp_code_o == 8'h03 && $stable(sample_rate_o))
    else $error("rate code span not enforced");
  rate_store_a: assert property (
    wr && rsel && write_allow_i && req_wdata_i <= 16'h0002
      |=> sample_rate_o == $past(req_wdata_i[1:0]) && !rsp_exc_o)
    else $error("rate code not stored");
endmodule : tor_regs_sva

bind tor_regs tor_regs_sva u_tor_regs_sva (.*);

// >>> tb/tor_regs_test.sv
// self-checking bench of the offset, rate and id register bank
`timescale 1ns/1ps
module tor_regs_test;
  // identity words: values arbitrary
  localparam logic [15:0] IDW [5] = '{16'h1234, 16'h5678, 16'h5A3C,
                                      16'h0203, 16'h0007};
  localparam int          RC [3]  = '{40, 23, 11};
  localparam logic [15:0] G [4]   = '{16'h03E8, 16'hFC18, 16'h0064, 16'hFF9C};
  localparam logic [15:0] B [4]   = '{16'h03E9, 16'hFC17, 16'h0065, 16'hFF9B};
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic write_allow_i = 1'b1;
  logic signed [15:0] angle_x_i = 16'sd100;
  logic signed [15:0] angle_y_i = -16'sd7;
  logic signed [15:0] accel_x_i = 16'sd50;
  logic signed [15:0] accel_y_i = -16'sd3;
  logic [1:0] decimal_x_i = 2'h0;
  logic [1:0] decimal_y_i = 2'h0;
  logic req_valid_i, req_write_i, rsp_valid_o, rsp_exc_o, sample_tick_o;
  logic [15:0] req_addr_i, req_wdata_i, rsp_data_o;
  logic [15:0] angle_result_x_o, angle_result_y_o;
  logic [15:0] accel_result_x_o, accel_result_y_o;
  logic [7:0] rsp_code_o;
  logic [1:0] sample_rate_o;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  tor_regs #(.RATE0_CYC(40), .RATE1_CYC(23), .RATE2_CYC(11),
    .SERIAL_HI(IDW[0]), .SERIAL_LO(IDW[1]), .DEV_ID(IDW[2]),
    .FW_VER(IDW[3]), .BUILD_VER(IDW[4])) u_tor_regs (.*);

  tor_master_model u_tor_master_model (.sys_clk_i(sys_clk_i),
    .req_valid_o(req_valid_i), .req_write_o(req_write_i),
    .req_addr_o(req_addr_i), .req_wdata_o(req_wdata_i),
    .rsp_valid_i(rsp_valid_o), .rsp_code_i(rsp_code_o),
    .rsp_data_i(rsp_data_o));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic test_done();
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  // the run needs under a thousand cycles; the ceiling leaves slack
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic cmp(input logic [15:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic access(input logic w, input logic [15:0] a, d,
                        input logic [7:0] ec, input logic [15:0] ed);
    logic [7:0]  c;
    logic [15:0] q;
    u_tor_master_model.xfer(w, a, d, c, q);
    cmp({8'h00, c}, {8'h00, ec});
    if (ec == 8'h00)
      cmp(q, ed);
  endtask : access

  task automatic wait_tick(output int k);
    k = 0;
    do
    begin
      @(posedge sys_clk_i);
      #2;
      k++;
    end while (sample_tick_o !== 1'b1 && k < 100);
  endtask : wait_tick

  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    #2;
    reset_i = 1'b0;
    for (int i = 0; i < 4; i++)
      access(1'b0, 16'h0036 + 16'(i), 16'h0, 8'h00, 16'h0);
    access(1'b0, 16'h003F, 16'h0, 8'h00, 16'h0);
    for (int i = 0; i < 4; i++)
    begin
      access(1'b1, 16'h0036 + 16'(i), G[i], 8'h00, G[i]);
      access(1'b1, 16'h0036 + 16'(i), B[i], 8'h03, 16'h0);
      access(1'b0, 16'h0036 + 16'(i), 16'h0, 8'h00, G[i]);
    end
    for (int r = 3; r >= 0; r--)
    begin
      access(1'b1, 16'h003F, 16'(r), r > 2 ? 8'h03 : 8'h00, 16'(r));
      wait_tick(n);
      wait_tick(n);
      cmp(16'(n), 16'(RC[r > 2 ? 0 : r]));
    end
    for (int i = 0; i < 5; i++)
    begin
      access(1'b0, 16'hFFF0 + 16'(i), 16'h0, 8'h00, IDW[i]);
      access(1'b1, 16'hFFF0 + 16'(i), 16'h1, 8'h01, 16'h0);
    end
    access(1'b0, 16'h0047, 16'h0, 8'h00, tor_pkg::CAL_READ_VALUE);
    access(1'b1, 16'h003E, 16'h1, 8'h02, 16'h0);
    write_allow_i = 1'b0;
    access(1'b1, 16'h0036, 16'h0005, 8'h01, 16'h0);
    write_allow_i = 1'b1;
    for (int d = 0; d < 4; d++)
    begin
      decimal_x_i = 2'(d);
      decimal_y_i = 2'(d);
      wait_tick(n);
      @(posedge sys_clk_i);
      #2;
      cmp(angle_result_x_o, 16'(100 * 10 ** d - 1000));
      cmp(angle_result_y_o, 16'(-7 * 10 ** d + 1000));
      cmp(accel_result_x_o, 16'hFFCE);
      cmp(accel_result_y_o, 16'h0061);
      access(1'b0, 16'h0036, 16'h0, 8'h00, 16'h03E8);
    end
    // master clears the offset itself after a decimal change
    access(1'b1, 16'h0036, 16'h0, 8'h00, 16'h0);
    access(1'b0, 16'h0036, 16'h0, 8'h00, 16'h0);
    // mid-run reset: a nonzero offset must fall back to zero
    reset_i = 1'b1;
    @(posedge sys_clk_i);
    #2;
    reset_i = 1'b0;
    access(1'b0, 16'h0037, 16'h0, 8'h00, 16'h0);
    test_done();
  end
endmodule : tor_regs_test
